// file: verilog/sfp_pkg.sv
// constants, types and state layouts of the serial flash program path
// What this block does
// - with over a page of data only the final 256 bytes are kept.
// - program address wraps to the page start past the page's last byte.
// - short data programs only addressed bytes; rest of the page unchanged.
// - select must rise right after a whole data byte, else command is rejected.
// - select rise starts timed program; busy flag set, then busy and latch clear.
// - a program into a block-protected page is not executed.
// - program needs the write-enable latch set earlier by its command.
// - dual program takes two data bits per clock on lines 0 and 1.
// - dual program accepts one byte up to a full page.
// - quad program needs quad enable and the write-enable latch both set.
// - quad program takes four data bits per clock on lines 0 to 3.
// - three separate 512-byte secure areas, each erased and programmed alone.
// - secure erase runs only if select rises on the byte boundary.
// - valid secure erase starts a timed erase of sector-erase length with busy set.
// - address bits 15..12 of 1, 2, 3 pick the area, top byte zero.
// - a set area lock stays set until reset; erase to it is refused.
// - secure program takes 1 to 512 data bytes and needs the latch.
// - secure program starts a timed cycle of page-program length with busy set.
// - secure program to a locked area is ignored, contents untouched.
// - low nine address bits give the start byte; bits 11..9 must be zero.
package sfp_pkg;

	localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
	localparam logic [7:0] OP_SINGLE_PROG   = 8'h02;
	localparam logic [7:0] OP_DUAL_PROG     = 8'hA2;
	localparam logic [7:0] OP_QUAD_PROG     = 8'h32;
	localparam logic [7:0] OP_SECURE_ERASE  = 8'h44;
	localparam logic [7:0] OP_SECURE_PROG   = 8'h42;

	localparam logic [5:0] OPCODE_BITS      = 6'h08;
	localparam logic [5:0] HEADER_BITS      = 6'h20;
	localparam logic [3:0] BYTE_BITS        = 4'h8;
	localparam int         PAGE_BYTES       = 256;
	localparam int         SECURE_BYTES     = 512;
	localparam int         SECURE_AREAS     = 3;
	localparam logic [9:0] BYTE_COUNT_MAX   = 10'h200;
	localparam logic [7:0] SECURE_TOP_BYTE  = 8'h00;
	localparam logic [3:0] SECURE_SEL_FIRST = 4'h1;
	localparam logic [3:0] SECURE_SEL_LAST  = 4'h3;
	localparam logic [2:0] SECURE_PAD       = 3'h0;
	localparam logic [7:0] ERASED_BYTE      = 8'hFF;
	localparam logic [4:0] BLOCK_COUNT      = 5'h10;

	localparam int CLOCK_MHZ            = 20;
	localparam int PAGE_PROGRAM_TIME_US = 1000;
	localparam int SECTOR_ERASE_TIME_US = 50000;
	localparam int PAGE_PROGRAM_CYCLES  = PAGE_PROGRAM_TIME_US * CLOCK_MHZ;
	localparam int SECTOR_ERASE_CYCLES  = SECTOR_ERASE_TIME_US * CLOCK_MHZ;

	localparam logic       RESET_LATCH = 1'b0;
	localparam logic [2:0] RESET_LOCKS = 3'h0;

	typedef enum logic [1:0] {SFP_IDLE, SFP_WRITE, SFP_WAIT} sfp_state_t;
	typedef enum logic [1:0] {SFP_MAIN_PROG, SFP_SEC_ERASE, SFP_SEC_PROG} sfp_cmd_t;

	typedef struct packed {
		logic        lockMeta;
		logic        lockSeen;
		logic [5:0]  bitCnt;
		logic [7:0]  opcode;
		logic [23:0] addr;
		logic [7:0]  shift;
		logic [3:0]  dataBits;
		logic [9:0]  byteCnt;
		logic [8:0]  wrPtr;
	} sfp_link_t;

	typedef struct packed {
		logic        csMeta;
		logic        csSync;
		logic        csPrev;
		sfp_state_t  state;
		sfp_cmd_t    cmd;
		logic        write_enable_latch;
		logic        write_in_progress;
		logic        walking;
		logic [2:0]  lock;
		logic [23:0] timer;
		logic [9:0]  idx;
		logic [9:0]  total;
		logic [8:0]  base;
		logic [23:0] addr;
		logic        progWe;
		logic [23:0] progAddr;
		logic [7:0]  progData;
		logic [7:0]  secRd;
		logic        rejected;
	} sfp_core_t;

endpackage

// file: verilog/sfp_program_path.sv
// program, dual and quad program and secure-area erase and program of a serial flash
`timescale 1ns/1ns
module sfp_program_path #(
	parameter int ADDR_WIDTH          = 20,
	parameter int PAGE_PROGRAM_CYCLES = sfp_pkg::PAGE_PROGRAM_CYCLES,
	parameter int SECTOR_ERASE_CYCLES = sfp_pkg::SECTOR_ERASE_CYCLES
) (
	input  wire logic                  clock,
	input  wire logic                  rstn,
	input  wire logic                  serialClock,
	input  wire logic                  chipSelectN,
	input  wire logic [3:0]            dataLine,
	input  wire logic                  quadEnable,
	input  wire logic [4:0]            blockProtect,
	input  wire logic [2:0]            lockSet,
	input  wire logic [1:0]            secReadArea,
	input  wire logic [8:0]            secReadOffset,
	output logic                       writeEnableLatch,
	output logic                       writeInProgress,
	output logic [2:0]                 secureAreaLockBits,
	output logic                       arrayWriteStrobe,
	output logic [ADDR_WIDTH-1:0]      arrayWriteAddr,
	output logic [7:0]                 arrayWriteData,
	output logic [7:0]                 secReadData,
	output logic                       commandRejected
);
	import sfp_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// elaboration checks
	// the timed cycle must outlast the longest byte walk (one whole secure area
	// plus the hand-over cycles) and must fit into the 24-bit busy timer

	if (ADDR_WIDTH < 17 || ADDR_WIDTH > 24) begin : g_bad_width
		$error("address width must be 17 to 24");
	end
	if (PAGE_PROGRAM_CYCLES < SECURE_BYTES + 2 || PAGE_PROGRAM_CYCLES >= (1 << 24)) begin : g_bad_pp
		$error("program cycle count out of range");
	end
	if (SECTOR_ERASE_CYCLES < SECURE_BYTES + 2 || SECTOR_ERASE_CYCLES >= (1 << 24)) begin : g_bad_se
		$error("erase cycle count out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	// link side, clocked by the serial clock; only the frame-open flag is cleared while deselected

	sfp_link_t  lk;
	sfp_link_t  next_lk;
	sfp_core_t  cr;
	sfp_core_t  next_cr;
	logic       linkRstn;
	logic       frameOpen;
	logic [7:0] pageBuf [SECURE_BYTES];
	logic       bufWe;
	logic [8:0] bufAddr;
	logic [7:0] bufData;

	// only the frame-open flag is cleared while select is high; the decoded fields
	// must survive the rise, because the core decodes them after it
	assign linkRstn = rstn & ~chipSelectN;

	// shift in opcode, address and data; completed bytes go into the page buffer
	always_comb begin
		logic [2:0] width;
		logic [3:0] filled;
		logic [7:0] merged;
		logic       isProgOp;
		logic       isSecProg;
		sfp_link_t  cur;
		// the first edge of a frame counts from zero; the old counts stay for the core
		cur       = lk;
		if (!frameOpen) begin
			cur.bitCnt   = 6'h00;
			cur.dataBits = 4'h0;
			cur.byteCnt  = 10'h000;
		end
		width     = 3'h1;
		filled    = 4'h0;
		merged    = 8'h00;
		next_lk   = cur;
		bufWe     = 1'b0;
		bufAddr   = lk.wrPtr;
		bufData   = 8'h00;
		isSecProg = (lk.opcode == OP_SECURE_PROG);
		isProgOp  = isSecProg || lk.opcode == OP_SINGLE_PROG
			|| lk.opcode == OP_DUAL_PROG || lk.opcode == OP_QUAD_PROG;
		next_lk.lockMeta = cr.walking;
		next_lk.lockSeen = lk.lockMeta;
		if (cur.bitCnt < OPCODE_BITS) begin
			next_lk.opcode = {lk.opcode[6:0], dataLine[0]};
			next_lk.bitCnt = cur.bitCnt + 6'h01;
		end else if (cur.bitCnt < HEADER_BITS) begin
			next_lk.addr   = {lk.addr[22:0], dataLine[0]};
			next_lk.bitCnt = cur.bitCnt + 6'h01;
			// start byte: nine bits for secure areas, eight within a page
			if (isSecProg) begin
				next_lk.wrPtr = {lk.addr[7:0], dataLine[0]};
			end else begin
				next_lk.wrPtr = {1'b0, lk.addr[6:0], dataLine[0]};
			end
		end else begin
			if (lk.opcode == OP_DUAL_PROG) begin
				width  = 3'h2;
				merged = {lk.shift[5:0], dataLine[1:0]};
			end else if (lk.opcode == OP_QUAD_PROG) begin
				width  = 3'h4;
				merged = {lk.shift[3:0], dataLine[3:0]};
			end else begin
				merged = {lk.shift[6:0], dataLine[0]};
			end
			filled            = cur.dataBits + {1'b0, width};
			next_lk.shift     = merged;
			next_lk.dataBits  = filled;
			if (filled == BYTE_BITS) begin
				next_lk.dataBits = 4'h0;
				if (cur.byteCnt != BYTE_COUNT_MAX) begin
					next_lk.byteCnt = cur.byteCnt + 10'h001;
				end
				// buffer stays frozen while the core is still copying out of it
				bufWe   = isProgOp && !lk.lockSeen;
				bufData = merged;
				if (isSecProg) begin
					next_lk.wrPtr = lk.wrPtr + 9'h001;
				end else begin
					next_lk.wrPtr = {1'b0, lk.wrPtr[7:0] + 8'h01};
				end
			end
		end
	end

	// register the link state; only power-on reset clears it, so it outlives the frame
	always_ff @(posedge serialClock or negedge rstn) begin
		if (!rstn) begin
			lk <= '0;
		end else begin
			lk <= next_lk;
		end
	end

	// set on the first serial clock of a frame and cleared at once when select rises;
	// it tells the link logic to start counting afresh
	always_ff @(posedge serialClock or negedge linkRstn) begin
		if (!linkRstn) begin
			frameOpen <= 1'b0;
		end else begin
			frameOpen <= 1'b1;
		end
	end

	// page buffer, indexed by the byte offset within the page or area
	// written in the serial clock domain, read by the core only while it walks,
	// when the link side has stopped writing to it
	always_ff @(posedge serialClock) begin
		if (bufWe) begin
			pageBuf[bufAddr] <= bufData;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// core side: decode at the end of the frame and run the timed cycle

	logic [7:0]  secMem [SECURE_AREAS * SECURE_BYTES];
	logic        secWe;
	logic [10:0] secWaddr;
	logic [7:0]  secWdata;

	// true when the addressed 64 KB block falls in the protected range
	// code n in bits 2..0 protects 2^(n-1) blocks for n of 1 to 5, codes 6 and 7 protect none;
	// bit 3 picks the bottom end, bit 4 protects everything
	function automatic logic blockIsProtected(input logic [4:0] bp, input logic [3:0] blk);
		logic [4:0] count;
		count = 5'h00;
		if (bp[2:0] != 3'h0) begin
			count = 5'h01 << (bp[2:0] - 3'h1);
		end
		if (count > BLOCK_COUNT || bp[4]) begin
			count = BLOCK_COUNT;
		end
		if (bp[3]) begin
			blockIsProtected = {1'b0, blk} < count;
		end else begin
			blockIsProtected = {1'b0, blk} >= BLOCK_COUNT - count;
		end
	endfunction

	// decode, check conditions, walk the bytes and count out the busy time
	always_comb begin
		logic       rise;
		logic       onByte;
		logic       secAddrOk;
		logic [1:0] area;
		logic [8:0] offset;
		logic [9:0] span;
		rise      = cr.csSync && !cr.csPrev;
		onByte    = lk.bitCnt == HEADER_BITS && lk.dataBits == 4'h0;
		secAddrOk = lk.addr[23:16] == SECURE_TOP_BYTE
			&& lk.addr[15:12] >= SECURE_SEL_FIRST
			&& lk.addr[15:12] <= SECURE_SEL_LAST
			&& lk.addr[11:9] == SECURE_PAD;
		area      = cr.addr[13:12] - 2'h1;
		offset    = cr.base + cr.idx[8:0];
		span      = 10'h000;
		secWe     = 1'b0;
		secWaddr  = 11'h000;
		secWdata  = ERASED_BYTE;
		next_cr   = cr;
		next_cr.csMeta   = chipSelectN;
		next_cr.csSync   = cr.csMeta;
		next_cr.csPrev   = cr.csSync;
		next_cr.progWe   = 1'b0;
		next_cr.rejected = 1'b0;
		next_cr.lock     = cr.lock | lockSet;
		if (secReadArea < 2'h3) begin
			next_cr.secRd = secMem[{secReadArea, secReadOffset}];
		end else begin
			next_cr.secRd = ERASED_BYTE;
		end
		case (cr.state)
			SFP_IDLE: begin
				// link state is frozen once select is high, so it is read directly
				// the serial clock stands still between frames, and the select path
				// gives the link flops time to settle before these fields are used
				if (rise && !cr.write_in_progress) begin
					next_cr.addr = lk.addr;
					if (lk.opcode == OP_WRITE_ENABLE && lk.bitCnt == OPCODE_BITS) begin
						next_cr.write_enable_latch = 1'b1;
					end else if (lk.opcode == OP_SINGLE_PROG || lk.opcode == OP_DUAL_PROG
						|| lk.opcode == OP_QUAD_PROG) begin
						span = (lk.byteCnt >= 10'(PAGE_BYTES)) ? 10'(PAGE_BYTES) : lk.byteCnt;
						if (!onByte || lk.byteCnt == 10'h000) begin
							next_cr.rejected = 1'b1;
						end else if (!cr.write_enable_latch) begin
							next_cr.rejected = 1'b1;
						end else if (lk.opcode == OP_QUAD_PROG && !quadEnable) begin
							next_cr.rejected = 1'b1;
						end else if (blockIsProtected(blockProtect, lk.addr[19:16])) begin
							next_cr.rejected = 1'b1;
						end else begin
							next_cr.cmd     = SFP_MAIN_PROG;
							next_cr.state   = SFP_WRITE;
							next_cr.write_in_progress     = 1'b1;
							next_cr.walking = 1'b1;
							next_cr.timer   = 24'(PAGE_PROGRAM_CYCLES);
							next_cr.idx     = 10'h000;
							next_cr.total   = span;
							// full page: start at zero; short: start at the address
							next_cr.base    = (lk.byteCnt >= 10'(PAGE_BYTES))
								? 9'h000 : {1'b0, lk.addr[7:0]};
						end
					end else if (lk.opcode == OP_SECURE_ERASE) begin
						if (!onByte || lk.byteCnt != 10'h000) begin
							next_cr.rejected = 1'b1;
						end else if (!cr.write_enable_latch || !secAddrOk) begin
							next_cr.rejected = 1'b1;
						end else if (cr.lock[lk.addr[13:12] - 2'h1]) begin
							next_cr.rejected = 1'b1;
						end else begin
							next_cr.cmd     = SFP_SEC_ERASE;
							next_cr.state   = SFP_WRITE;
							next_cr.write_in_progress     = 1'b1;
							next_cr.walking = 1'b1;
							next_cr.timer   = 24'(SECTOR_ERASE_CYCLES);
							next_cr.idx     = 10'h000;
							next_cr.total   = 10'(SECURE_BYTES);
							next_cr.base    = 9'h000;
						end
					end else if (lk.opcode == OP_SECURE_PROG) begin
						if (!onByte || lk.byteCnt == 10'h000) begin
							next_cr.rejected = 1'b1;
						end else if (!cr.write_enable_latch || !secAddrOk) begin
							next_cr.rejected = 1'b1;
						end else if (cr.lock[lk.addr[13:12] - 2'h1]) begin
							next_cr.rejected = 1'b1;
						end else begin
							next_cr.cmd     = SFP_SEC_PROG;
							next_cr.state   = SFP_WRITE;
							next_cr.write_in_progress     = 1'b1;
							next_cr.walking = 1'b1;
							next_cr.timer   = 24'(PAGE_PROGRAM_CYCLES);
							next_cr.idx     = 10'h000;
							next_cr.total   = lk.byteCnt;
							next_cr.base    = (lk.byteCnt == BYTE_COUNT_MAX)
								? 9'h000 : lk.addr[8:0];
						end
					end
				end
			end
			SFP_WRITE: begin
				next_cr.timer = cr.timer - 24'h000001;
				case (cr.cmd)
					SFP_MAIN_PROG: begin
						// offsets wrap inside the page
						next_cr.progWe   = 1'b1;
						next_cr.progAddr = {cr.addr[23:8], offset[7:0]};
						next_cr.progData = pageBuf[{1'b0, offset[7:0]}];
					end
					SFP_SEC_ERASE: begin
						secWe    = 1'b1;
						secWaddr = {area, cr.idx[8:0]};
						secWdata = ERASED_BYTE;
					end
					SFP_SEC_PROG: begin
						// programming only clears bits
						secWe    = 1'b1;
						secWaddr = {area, offset};
						secWdata = secMem[{area, offset}] & pageBuf[offset];
					end
					default: begin
						secWe = 1'b0;
					end
				endcase
				next_cr.idx = cr.idx + 10'h001;
				if (cr.idx + 10'h001 >= cr.total) begin
					next_cr.state   = SFP_WAIT;
					next_cr.walking = 1'b0;
				end
			end
			SFP_WAIT: begin
				next_cr.timer = cr.timer - 24'h000001;
				// the latch falls together with the busy flag
				if (cr.timer == 24'h000001) begin
					next_cr.state = SFP_IDLE;
					next_cr.write_in_progress   = 1'b0;
					next_cr.write_enable_latch   = 1'b0;
				end
			end
			default: begin
				next_cr.state = SFP_IDLE;
			end
		endcase
	end

	// register the core state
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cr        <= '0;
			cr.csMeta <= 1'b1;
			cr.csSync <= 1'b1;
			cr.csPrev <= 1'b1;
			cr.write_enable_latch    <= RESET_LATCH;
			cr.lock   <= RESET_LOCKS;
		end else begin
			cr <= next_cr;
		end
	end

	// secure area storage
	// no reset: contents stay undefined until erased; programming only clears bits of them
	always_ff @(posedge clock) begin
		if (secWe) begin
			secMem[secWaddr] <= secWdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, each straight from a core flip-flop

	assign writeEnableLatch   = cr.write_enable_latch;
	assign writeInProgress    = cr.write_in_progress;
	assign secureAreaLockBits = cr.lock;
	assign arrayWriteStrobe   = cr.progWe;
	assign arrayWriteAddr     = cr.progAddr[ADDR_WIDTH-1:0];
	assign arrayWriteData     = cr.progData;
	assign secReadData        = cr.secRd;
	assign commandRejected    = cr.rejected;

endmodule

// file: verification/sfp_chk.sv
// port assertions of the serial flash program path
`timescale 1ns/1ns
module sfp_chk #(
	parameter int PAGE_PROGRAM_CYCLES = 600,
	parameter int SECTOR_ERASE_CYCLES = 700
) (
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic       chipSelectN,
	input  wire logic [2:0] lockSet,
	input  wire logic       writeEnableLatch,
	input  wire logic       writeInProgress,
	input  wire logic [2:0] secureAreaLockBits,
	input  wire logic       arrayWriteStrobe,
	input  wire logic       commandRejected
);
	logic [23:0] busyCnt;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////
	// cycles the busy flag has stood high
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) busyCnt <= 24'h0;
		else busyCnt <= writeInProgress ? busyCnt + 24'h1 : 24'h0;
	end
	////////////////////////////////////////////////////////////////
	// cycle start, length and end
	a_start_needs_latch: assert property ($rose(writeInProgress) |-> writeEnableLatch)
		else $error("busy started without latch");
	a_end_clears_latch: assert property ($fell(writeInProgress) |-> $fell(writeEnableLatch))
		else $error("latch not cleared with busy");
	a_busy_length: assert property ($fell(writeInProgress) |->
		busyCnt == PAGE_PROGRAM_CYCLES || busyCnt == SECTOR_ERASE_CYCLES)
		else $error("busy length wrong");
	a_start_after_select: assert property ($rose(writeInProgress) |->
		$past(chipSelectN, 1) && $past(chipSelectN, 2) && $past(chipSelectN, 3))
		else $error("busy without select rise");
	a_strobe_while_busy: assert property (arrayWriteStrobe |-> writeInProgress)
		else $error("strobe outside cycle");
	a_reject_changes_none: assert property (commandRejected |->
		!writeInProgress ##1 (!writeInProgress && $stable(writeEnableLatch)))
		else $error("refused command had effect");
	a_lock_sticky: assert property (($past(secureAreaLockBits) & ~secureAreaLockBits) == 3'h0)
		else $error("lock bit cleared");
	a_lock_takes_set: assert property (|lockSet |->
		##2 ((secureAreaLockBits & $past(lockSet, 2)) == $past(lockSet, 2)))
		else $error("lock bit not set");
	c_cycle: cover property ($rose(writeInProgress));
	c_reject: cover property (commandRejected);
	c_burst: cover property (arrayWriteStrobe ##1 arrayWriteStrobe);
endmodule

bind sfp_program_path sfp_chk #(
	.PAGE_PROGRAM_CYCLES(PAGE_PROGRAM_CYCLES),
	.SECTOR_ERASE_CYCLES(SECTOR_ERASE_CYCLES)
) chk (.clock, .rstn, .chipSelectN, .lockSet, .writeEnableLatch, .writeInProgress,
	.secureAreaLockBits, .arrayWriteStrobe, .commandRejected);

// file: verification/sfp_host.sv
// spi host model: frames on its own link clock, which stands still between frames
`timescale 1ns/1ns
module sfp_host (
	output logic       serialClock,
	output logic       chipSelectN,
	output logic [3:0] dataLine
);
	import sfp_pkg::*;
	logic [7:0] dat [0:599];
	// idle: select high, clock low
	initial begin
		serialClock = 1'b0;
		chipSelectN = 1'b1;
		dataLine    = 4'h5;
	end
	// one link clock, w lines carry v, unused lines inverted
	task automatic put(input logic [3:0] v, input int w);
		logic [3:0] m;
		m = 4'((1 << w) - 1);
		dataLine <= (~dataLine & ~m) | (v & m);
		#6 serialClock <= 1'b1;
		#6 serialClock <= 1'b0;
	endtask
	// opcode, address, n data bytes on w lines, xb stray clocks
	task automatic frame(input logic [7:0] op, input logic [23:0] a, input int n, input int w,
		input int xb);
		int i;
		int b;
		#3 chipSelectN <= 1'b0;
		for (b = 7; b >= 0; b--) put({3'h0, op[b]}, 1);
		if (op != OP_WRITE_ENABLE) for (b = 23; b >= 0; b--) put({3'h0, a[b]}, 1);
		for (i = 0; i < n; i++) for (b = 8 - w; b >= 0; b -= w) put(4'(dat[i] >> b), w);
		for (i = 0; i < xb; i++) put(4'h0, w);
		#3 chipSelectN <= 1'b1;
		dataLine <= ~dataLine;
	endtask
endmodule

// file: verification/tb.sv
// testbench of the serial flash program path
`timescale 1ns/1ns
module tb;
	import sfp_pkg::*;
	localparam int PPC   = 600;
	localparam int SEC   = 700;
	localparam int LIMIT = 40000;
	logic        clock         = 1'b0;
	logic        rstn          = 1'b0;
	logic        quadEnable    = 1'b0;
	logic [4:0]  blockProtect  = 5'h00;
	logic [2:0]  lockSet       = 3'h0;
	logic [1:0]  secReadArea   = 2'h0;
	logic [8:0]  secReadOffset = 9'h000;
	logic        serialClock, chipSelectN, writeEnableLatch, writeInProgress;
	logic        arrayWriteStrobe, commandRejected;
	logic [3:0]  dataLine;
	logic [2:0]  secureAreaLockBits;
	logic [19:0] arrayWriteAddr;
	logic [7:0]  arrayWriteData, secReadData;
	logic [28:0] expQ [$];
	int          nMismatch = 0;
	int          numChecks = 0;
	int          cyc       = 0;
	int          seed      = 32'h2088;
	always #25 clock = ~clock;
	sfp_program_path #(.PAGE_PROGRAM_CYCLES(PPC), .SECTOR_ERASE_CYCLES(SEC)) dut (.clock, .rstn,
		.serialClock, .chipSelectN, .dataLine, .quadEnable, .blockProtect, .lockSet,
		.secReadArea, .secReadOffset, .writeEnableLatch, .writeInProgress, .secureAreaLockBits,
		.arrayWriteStrobe, .arrayWriteAddr, .arrayWriteData, .secReadData, .commandRejected);
	sfp_host host (.serialClock, .chipSelectN, .dataLine);
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [28:0] seen, input logic [28:0] exp);
		numChecks++;
		if (seen !== exp) begin
			nMismatch++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic giveVerdict();
		$display("checks %0d, mismatches %0d", numChecks, nMismatch);
		if (nMismatch == 0 && numChecks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// enable frame, then one write frame, then wait out the cycle
	task automatic run(input logic [7:0] op, input logic [23:0] a, input int n, input int w,
		input int xb, input bit rej);
		host.frame(OP_WRITE_ENABLE, 24'h0, 0, 1, 0);
		repeat (6) @(posedge clock);
		check(29'(writeEnableLatch), 29'h1);
		if (rej) expQ.push_back({1'b1, 28'h0});
		host.frame(op, a, n, w, xb);
		repeat (8) @(posedge clock);
		while (writeInProgress !== 1'b0) @(posedge clock);
		repeat (2) @(posedge clock);
		check(29'(writeEnableLatch), 29'(rej));
	endtask
	// random page data and the strobes it must give
	task automatic prog(input logic [7:0] op, input logic [23:0] a, input int n, input int w,
		input bit rej);
		int i;
		int j;
		for (i = 0; i < n; i++) host.dat[i] = 8'($random(seed));
		if (!rej && n >= 256) begin
			for (i = 0; i < 256; i++) begin
				j = (i - a[7:0]) & 255;
				while (j + 256 < n) j += 256;
				expQ.push_back({1'b0, a[19:8], 8'(i), host.dat[j]});
			end
		end else if (!rej) begin
			for (i = 0; i < n; i++) expQ.push_back({1'b0, a[19:8], 8'(a[7:0] + i), host.dat[i]});
		end
		run(op, a, n, w, 0, rej);
	endtask
	task automatic secRead(input logic [1:0] area, input logic [8:0] off, input logic [7:0] exp);
		@(posedge clock);
		secReadArea   <= area;
		secReadOffset <= off;
		repeat (2) @(posedge clock);
		#1 check(29'(secReadData), 29'(exp));
	endtask
	////////////////////////////////////////////////////////////////
	// each strobe or refusal takes the oldest note
	always @(posedge clock) begin
		if (rstn && (arrayWriteStrobe === 1'b1 || commandRejected === 1'b1)) begin
			if (expQ.size() == 0) check(29'h0, 29'h1FFFFFFF);
			else check(commandRejected ? 29'h10000000 : {1'b0, arrayWriteAddr, arrayWriteData},
				expQ.pop_front());
		end
	end
	// hang guard
	always @(posedge clock) begin
		cyc++;
		if (cyc == LIMIT) begin
			nMismatch++;
			giveVerdict();
		end
	end
	initial begin
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		repeat (4) @(posedge clock);
		prog(OP_SINGLE_PROG, 24'h0100FE, 3, 1, 0);
		prog(OP_SINGLE_PROG, 24'h020000, 258, 1, 0);
		prog(OP_DUAL_PROG, 24'h030010, 5, 2, 0);
		prog(OP_QUAD_PROG, 24'h030080, 4, 4, 1);
		quadEnable <= 1'b1;
		prog(OP_QUAD_PROG, 24'h030080, 4, 4, 0);
		// the finished cycle cleared the latch, so a bare program frame is refused
		expQ.push_back({1'b1, 28'h0});
		host.frame(OP_SINGLE_PROG, 24'h030000, 1, 1, 0);
		repeat (8) @(posedge clock);
		check(29'(writeEnableLatch), 29'h0);
		run(OP_SINGLE_PROG, 24'h030000, 1, 1, 3, 1);
		blockProtect <= 5'h01;
		prog(OP_SINGLE_PROG, 24'h0F0000, 1, 1, 1);
		prog(OP_SINGLE_PROG, 24'h000000, 1, 1, 0);
		blockProtect <= 5'h10;
		prog(OP_SINGLE_PROG, 24'h000000, 1, 1, 1);
		blockProtect <= 5'h00;
		run(OP_SECURE_ERASE, 24'h001000, 0, 1, 0, 0);
		secRead(2'h0, 9'h1FF, ERASED_BYTE);
		run(OP_SECURE_ERASE, 24'h001000, 0, 1, 4, 1);
		run(OP_SECURE_ERASE, 24'h004000, 0, 1, 0, 1);
		host.dat[0] = 8'($random(seed));
		host.dat[1] = 8'($random(seed));
		run(OP_SECURE_PROG, 24'h0011FF, 2, 1, 0, 0);
		secRead(2'h0, 9'h1FF, host.dat[0]);
		secRead(2'h0, 9'h000, host.dat[1]);
		run(OP_SECURE_PROG, 24'h001200, 1, 1, 0, 1);
		lockSet <= 3'h1;
		@(posedge clock);
		lockSet <= 3'h0;
		repeat (3) @(posedge clock);
		check(29'(secureAreaLockBits), 29'h1);
		run(OP_SECURE_ERASE, 24'h001000, 0, 1, 0, 1);
		run(OP_SECURE_PROG, 24'h001000, 1, 1, 0, 1);
		secRead(2'h0, 9'h000, host.dat[1]);
		run(OP_SECURE_ERASE, 24'h002000, 0, 1, 0, 0);
		secRead(2'h1, 9'h0AA, ERASED_BYTE);
		secRead(2'h0, 9'h1FF, host.dat[0]);
		check(29'(expQ.size()), 29'h0);
		giveVerdict();
	end
endmodule
